// *** src/serial_memory_spi_pin_interface.sv ***
// Serial memory slave: pin front end, command engine, write FIFO, array
`timescale 1ns/1ps

// ---------------------------------------------
// Write FIFO
// ---------------------------------------------
module wr_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW:0] wp;
   logic [PW:0] rp;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire full = (wp[PW] != rp[PW]) && (wp[PW-1:0] == rp[PW-1:0]);

   // Handshake flags
   assign in_ready = !full;
   assign out_valid = (wp != rp);
   assign out_data = store[rp[PW-1:0]];

   // Pointers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (push) wp <= wp + 1'b1;
         if (pop) rp <= rp + 1'b1;
      end
   end

   // Storage
   always_ff @(posedge clk) begin
      if (push) store[wp[PW-1:0]] <= in_data;
   end
endmodule

// ---------------------------------------------
// Top
// ---------------------------------------------
// Behaviour
// RULE1 - Array of 131072 bytes, random read and write anywhere.
// RULE2 - Chip select is active low; traffic only while it is low.
// RULE3 - Chip select high: standby, inputs ignored, output high impedance.
// RULE4 - Output driven only while read data is being returned.
// RULE5 - Pause low forces output to high impedance.
// RULE6 - Output changes only on falling serial clock edges.
// RULE7 - Input sampled on rising serial clock edges only.
// RULE8 - Write-protect low refuses status writes when status lock set.
// RULE9 - Master may tie serial input and output into one line.
// RULE10 - Master keeps serial clock at or below 40 MHz.
// RULE11 - Mode 0 and mode 3 both supported.
// RULE12 - Fully static; clock may stop anywhere without state loss.
// RULE13 - Pause low suspends the operation, keeping all state.
// RULE14 - Pause low: chip select and clock transitions ignored.
// RULE15 - Master changes pause only while chip select is low.
// RULE16 - Shared clock and data; own chip select and pause per device.
// RULE17 - Mode picked from clock level when chip select falls.
// RULE18 - One command per chip select low period; first byte is command.
// RULE19 - Master raises chip select only on a byte boundary.
// RULE20 - Chip select rise discards partial command, back to idle.
module serial_memory_spi_pin_interface (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   input wire logic HOLD_N,
   input wire logic WP_N,
   output logic SO,
   output logic SO_OE_N,
   output logic WR_READY
);
   import spi_mem_pkg::*;

   logic [DATA_W-1:0] mem [MEM_WORDS]; // RULE1
   logic [SYNC_STAGES-1:0] cs_sy;
   logic [SYNC_STAGES-1:0] ck_sy;
   logic [SYNC_STAGES-1:0] si_sy;
   logic [SYNC_STAGES-1:0] hd_sy;
   logic [SYNC_STAGES-1:0] wp_sy;
   logic cs_prev;
   logic ck_prev;
   logic mode3;
   logic skip_fall;
   phase_t phase;
   logic [2:0] bit_cnt;
   logic [1:0] addr_cnt;
   logic [6:0] shift;
   logic [7:0] cmd;
   logic [ADDR_W-1:0] addr;
   logic [7:0] out_byte;
   logic [7:0] status;
   logic sleeping;
   logic driving;
   logic fetch;
   logic pend_valid;
   wr_entry_t pend;
   logic q_valid;
   wr_entry_t q_data;
   wire WR_IN_READY;

   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         cs_sy <= '1;
         ck_sy <= '0;
         si_sy <= '0;
         hd_sy <= '1;
         wp_sy <= '1;
      end else begin
         cs_sy <= {cs_sy[0], CS_N};
         ck_sy <= {ck_sy[0], SCK};
         si_sy <= {si_sy[0], SI};
         hd_sy <= {hd_sy[0], HOLD_N};
         wp_sy <= {wp_sy[0], WP_N};
      end
   end

   // ---------------------------------------------
   // Edge detection and decode
   // ---------------------------------------------
   wire cs_s = cs_sy[1];
   wire ck_s = ck_sy[1];
   wire si_s = si_sy[1];
   wire hold_ok = hd_sy[1]; // RULE13
   wire wp_s = wp_sy[1];
   wire cs_fall = hold_ok && cs_prev && !cs_s; // RULE14
   wire cs_rise = hold_ok && !cs_prev && cs_s; // RULE14
   wire sel = !cs_s && !cs_prev; // RULE2
   wire ck_rise = hold_ok && sel && !ck_prev && ck_s; // RULE7
   wire ck_fall = hold_ok && sel && ck_prev && !ck_s; // RULE6
   wire byte_done = ck_rise && (bit_cnt == 3'h7);
   wire [7:0] rx_byte = {shift, si_s};
   wire [1:0] bp = {status[SR_BP1], status[SR_BP0]};
   wire blk_prot = (bp == 2'b11) || (bp == 2'b10 && addr[16])
      || (bp == 2'b01 && addr[16:15] == 2'b11);
   wire sr_ok = status[SR_WEL]
      && !(status[SR_SRWD] && !wp_s); // RULE8
   wire wr_ok = status[SR_WEL] && !blk_prot;
   wire rd_phase = (phase == ST_RD) || (phase == ST_SRRD);
   wire last_addr = (addr_cnt == 2'(ADDR_BYTES - 1));

   // Output pin: driven only for read data, never while paused or idle
   assign SO_OE_N = !(driving && hold_ok && !cs_s); // RULE3 RULE4 RULE5
   assign WR_READY = !pend_valid;

   // ---------------------------------------------
   // Serial front end
   // ---------------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         cs_prev <= 1'b1;
         ck_prev <= 1'b0;
      end else if (hold_ok) begin
         cs_prev <= cs_s;
         ck_prev <= ck_s;
      end
   end

   // Mode capture at chip select fall
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         mode3 <= 1'b0;
      end else if (cs_fall) begin
         mode3 <= ck_s; // RULE17 RULE11
      end
   end

   // Bit shifter; state holds while clock is stopped or paused
   always_ff @(posedge MCLK) begin
      if (!RESETN || cs_rise || cs_fall) begin
         bit_cnt <= '0; // RULE20
         shift <= '0;
      end else if (ck_rise) begin
         bit_cnt <= bit_cnt + 1'b1; // RULE12
         shift <= rx_byte[6:0];
      end
   end

   // ---------------------------------------------
   // Command engine
   // ---------------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         phase <= ST_CMD;
         cmd <= '0;
         addr_cnt <= '0;
         addr <= '0;
         status <= SR_RESET;
         sleeping <= 1'b0;
         fetch <= 1'b0;
         pend_valid <= 1'b0;
         pend <= '0;
      end else begin
         fetch <= 1'b0;
         if (pend_valid && WR_IN_READY) pend_valid <= 1'b0;
         if (cs_rise || cs_fall) begin
            phase <= ST_CMD; // RULE18 RULE20
            addr_cnt <= '0;
         end else if (byte_done) begin
            unique case (phase)
               ST_CMD: begin
                  cmd <= rx_byte;
                  phase <= ST_SKIP; // RULE18
                  if (sleeping) begin
                     if (rx_byte == CMD_WAKE) sleeping <= 1'b0;
                  end else if (rx_byte == CMD_WREN) begin
                     status[SR_WEL] <= 1'b1;
                  end else if (rx_byte == CMD_WRDI) begin
                     status[SR_WEL] <= 1'b0;
                  end else if (rx_byte == CMD_SLEEP) begin
                     sleeping <= 1'b1;
                  end else if (rx_byte == CMD_RDSR) begin
                     phase <= ST_SRRD;
                  end else if (rx_byte == CMD_WRSR) begin
                     phase <= ST_SRWR;
                  end else if (rx_byte == CMD_READ
                        || rx_byte == CMD_WRITE) begin
                     phase <= ST_ADDR;
                  end
               end
               ST_ADDR: begin
                  addr <= ADDR_W'({addr, rx_byte});
                  addr_cnt <= addr_cnt + 1'b1;
                  if (last_addr) begin
                     phase <= (cmd == CMD_READ) ? ST_RD : ST_WR;
                     fetch <= (cmd == CMD_READ);
                  end
               end
               ST_RD: fetch <= 1'b1;
               ST_WR: begin
                  if (wr_ok) begin
                     pend_valid <= 1'b1;
                     pend.addr <= addr;
                     pend.data <= rx_byte;
                     addr <= addr + 1'b1; // Rolls over at top
                  end
               end
               ST_SRWR: begin
                  if (sr_ok) begin
                     status <= (rx_byte & SR_WMASK)
                        | (status & ~SR_WMASK); // RULE8
                  end
                  phase <= ST_SKIP;
               end
               ST_SRRD: phase <= ST_SRRD;
               ST_SKIP: phase <= ST_SKIP;
               default: phase <= ST_SKIP;
            endcase
         end
         if (fetch) addr <= addr + 1'b1;
      end
   end

   // ---------------------------------------------
   // Read data path and output shifter
   // ---------------------------------------------
   wire drain = q_valid && !fetch;

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         out_byte <= '0;
      end else if (fetch) begin
         out_byte <= mem[addr]; // RULE1
      end else if (phase == ST_SRRD && bit_cnt == 3'h0 && !ck_fall) begin
         out_byte <= status;
      end
   end

   // Array write from FIFO; reads take the port first
   always_ff @(posedge MCLK) begin
      if (drain) mem[q_data.addr] <= q_data.data; // RULE1
   end

   // Output bit changes on falling clock edges only
   always_ff @(posedge MCLK) begin
      if (!RESETN || cs_rise || cs_fall) begin
         SO <= 1'b0;
         driving <= 1'b0;
         skip_fall <= 1'b1;
      end else if (ck_fall) begin
         skip_fall <= 1'b0;
         if (rd_phase && !(mode3 && skip_fall)) begin // RULE11
            SO <= out_byte[3'h7 - bit_cnt]; // RULE6
            driving <= 1'b1; // RULE4
         end
      end
   end

   // Write FIFO
   wr_fifo #(
      .WIDTH($bits(wr_entry_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(MCLK),
      .rst_n(RESETN),
      .in_valid(pend_valid),
      .in_ready(WR_IN_READY),
      .in_data(pend),
      .out_valid(q_valid),
      .out_ready(!fetch),
      .out_data(q_data)
   );
endmodule

// *** src/spi_mem_pkg.sv ***
// Package: constants and types for the serial memory pin interface
package spi_mem_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int MEM_WORDS = 131072;
   localparam int FIFO_DEPTH = 32;
   localparam int ADDR_BYTES = 3;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SYNC_STAGES = 2;
   // Command codes
   localparam logic [7:0] CMD_WREN = 8'h06;
   localparam logic [7:0] CMD_WRDI = 8'h04;
   localparam logic [7:0] CMD_RDSR = 8'h05;
   localparam logic [7:0] CMD_WRSR = 8'h01;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_WRITE = 8'h02;
   localparam logic [7:0] CMD_SLEEP = 8'hB9;
   localparam logic [7:0] CMD_WAKE = 8'hAB;
   // Status field positions and reset value
   localparam int SR_SRWD = 7;
   localparam int SR_BP1 = 3;
   localparam int SR_BP0 = 2;
   localparam int SR_WEL = 1;
   localparam logic [7:0] SR_RESET = 8'h00;
   localparam logic [7:0] SR_WMASK = 8'hFD;
   typedef enum logic [2:0] {
      ST_CMD = 3'b000,
      ST_ADDR = 3'b001,
      ST_RD = 3'b010,
      ST_WR = 3'b011,
      ST_SRRD = 3'b100,
      ST_SRWR = 3'b101,
      ST_SKIP = 3'b110
   } phase_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } wr_entry_t;
endpackage

// *** testbench/spi_host_model.sv ***
// Bus master model driving select, clock, data and pause pins
`timescale 1ns/1ps
module spi_host_model (
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n,
   input wire logic so,
   input wire logic so_oe_n
);
   // -----------------------------------
   // Pin sequencing
   // -----------------------------------
   localparam realtime HALF = 62.5;
   logic mode;
   // Separate data lines kept; released line shows no stale bit
   wire so_line = so_oe_n ? ~so : so;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end
   // Clock level at select fall picks the mode
   task automatic start(input logic m);
      mode = m;
      sck = m;
      #HALF;
      cs_n = 1'b0;
      #HALF;
   endtask
   // Shift n bits MSB first; pause with clock pulses after bit hb
   task automatic xfer(input logic [7:0] tx, input int n, input int hb,
                       output logic [7:0] rx);
      for (int i = 0; i < n; i++) begin
         sck = 1'b0;
         si = tx[7-i];
         #HALF;
         sck = 1'b1;
         rx = {rx[6:0], so_line};
         #HALF;
         if (i == hb) begin
            hold_n = 1'b0;
            repeat (4) begin
               #HALF;
               sck = ~sck;
            end
            #HALF;
            hold_n = 1'b1;
            #HALF;
         end
      end
   endtask
   // Back to idle level, then deselect wherever the transfer left off
   task automatic stop;
      sck = mode;
      #HALF;
      cs_n = 1'b1;
      si = ~si;
      #HALF;
   endtask
endmodule

// *** testbench/spi_mem_pin_monitor.sv ***
// Checker on the pins of the serial memory slave
`timescale 1ns/1ps
module spi_mem_pin_monitor (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   input wire logic HOLD_N,
   input wire logic WP_N,
   input wire logic SO,
   input wire logic SO_OE_N,
   input wire logic WR_READY
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   // -----------------------------------
   // Clock fall age
   // -----------------------------------
   logic s1;
   logic s2;
   logic [3:0] since_fall;
   // Cycles since a synced serial clock fall
   always_ff @(posedge MCLK) begin
      s1 <= SCK;
      s2 <= s1;
   end
   always_ff @(posedge MCLK) begin
      if (!RESETN || (s2 && !s1)) since_fall <= 4'h0;
      else if (since_fall != 4'hF) since_fall <= since_fall + 4'h1;
   end
   chk_idle_hiz: assert property (CS_N [*5] |-> SO_OE_N)
      else $error("output driven while deselected");
   chk_hold_hiz: assert property (!HOLD_N [*5] |-> SO_OE_N)
      else $error("output driven while paused");
   chk_hold_freeze: assert property (!HOLD_N [*5] |-> $stable(SO))
      else $error("output moved while paused");
   chk_so_on_fall: assert property (!SO_OE_N && $past(!SO_OE_N)
      && $changed(SO) |-> since_fall < 4'h6)
      else $error("output changed away from a clock fall");
   chk_oe_start: assert property ($fell(SO_OE_N)
      |-> (since_fall < 4'h6 || !$past(HOLD_N, 3) || !$past(HOLD_N, 4))
      && !CS_N && HOLD_N)
      else $error("output enabled without cause");
   chk_cs_release: assert property ($rose(CS_N) |-> ##[1:5] SO_OE_N)
      else $error("output kept after deselect");
   chk_pause_release: assert property ($fell(HOLD_N) |-> ##[1:5] SO_OE_N)
      else $error("output kept after pause");
   chk_wr_pulse: assert property ($fell(WR_READY) |-> ##[1:4] WR_READY)
      else $error("write queue stuck");
   chk_reset_quiet: assert property (disable iff (1'b0)
      !RESETN |=> SO_OE_N && WR_READY)
      else $error("outputs active in reset");
   cover property ($fell(SO_OE_N));
   cover property (!HOLD_N [*5]);
   cover property ($fell(WR_READY));
endmodule
bind serial_memory_spi_pin_interface spi_mem_pin_monitor chk_u (
   .MCLK(MCLK), .RESETN(RESETN), .CS_N(CS_N), .SCK(SCK), .SI(SI),
   .HOLD_N(HOLD_N), .WP_N(WP_N), .SO(SO), .SO_OE_N(SO_OE_N),
   .WR_READY(WR_READY));

// *** testbench/tb_top.sv ***
// Self-checking bench for the serial memory pin interface
`timescale 1ns/1ps
module tb_top;
   import spi_mem_pkg::*;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic wp_n = 1'b1;
   wire cs_n, sck, si, hold_n, so, so_oe_n, wr_ready;
   int error_cnt = 0;
   int total_checks = 0;
   logic [7:0] sr = SR_RESET;
   logic [7:0] rx, d0, d1;
   logic [16:0] a;
   logic m;
   always #5 mclk = ~mclk;
   serial_memory_spi_pin_interface dut_u (.MCLK(mclk), .RESETN(resetn),
      .CS_N(cs_n), .SCK(sck), .SI(si), .HOLD_N(hold_n), .WP_N(wp_n),
      .SO(so), .SO_OE_N(so_oe_n), .WR_READY(wr_ready));
   spi_host_model mst_u (.cs_n(cs_n), .sck(sck), .si(si),
      .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n));
   // -----------------------------------
   // Helpers
   // -----------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("errors=%0d checks=%0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Status expected after a write with the latch set
   function automatic logic [7:0] sr_next(input logic [7:0] old,
                                          input logic [7:0] v, input logic wp);
      if (old[SR_SRWD] && !wp) return old;
      return (v & SR_WMASK) | (old & ~SR_WMASK);
   endfunction
   task automatic cmd(input logic [7:0] c, input logic md);
      mst_u.start(md);
      mst_u.xfer(c, 8, -1, rx);
      mst_u.stop;
   endtask
   task automatic rdsr(input logic md);
      mst_u.start(md);
      mst_u.xfer(CMD_RDSR, 8, -1, rx);
      mst_u.xfer(8'h00, 8, -1, rx);
      mst_u.stop;
      check(rx, sr);
   endtask
   task automatic wrsr(input logic [7:0] v);
      cmd(CMD_WREN, 1'b0);
      sr[SR_WEL] = 1'b1;
      mst_u.start(1'b0);
      mst_u.xfer(CMD_WRSR, 8, -1, rx);
      mst_u.xfer(v, 8, -1, rx);
      mst_u.stop;
      sr = sr_next(sr, v, wp_n);
      rdsr(1'b1);
   endtask
   task automatic open_at(input logic [7:0] c, input logic [16:0] ad,
                          input logic md);
      mst_u.start(md);
      mst_u.xfer(c, 8, -1, rx);
      mst_u.xfer({7'h00, ad[16]}, 8, -1, rx);
      mst_u.xfer(ad[15:8], 8, -1, rx);
      mst_u.xfer(ad[7:0], 8, -1, rx);
   endtask
   task automatic wr2(input logic [16:0] ad, input logic [7:0] x0, x1,
                      input logic md);
      cmd(CMD_WREN, md);
      sr[SR_WEL] = 1'b1;
      open_at(CMD_WRITE, ad, md);
      mst_u.xfer(x0, 8, -1, rx);
      mst_u.xfer(x1, 8, -1, rx);
      mst_u.stop;
   endtask
   task automatic rd2(input logic [16:0] ad, input logic [7:0] x0, x1,
                      input logic md, input int hb);
      open_at(CMD_READ, ad, md);
      mst_u.xfer(8'h00, 8, -1, rx);
      check(rx, x0);
      mst_u.xfer(8'h00, 8, hb, rx);
      check(rx, x1);
      mst_u.stop;
   endtask
   // -----------------------------------
   // Main sequence
   // -----------------------------------
   initial begin
      void'($urandom(32'h7EDA35DD));
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      repeat (4) @(negedge mclk);
      #1.25;
      check({7'h00, so_oe_n}, 8'h01);
      // Abort a command after four bits
      mst_u.start(1'b0);
      mst_u.xfer(CMD_WREN, 4, -1, rx);
      mst_u.stop;
      rdsr(1'b0);
      // Wrap at the top of the array, pause in mid byte
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      wr2(17'h1FFFF, d0, d1, 1'b0);
      rd2(17'h1FFFF, d0, d1, 1'b1, 3);
      repeat (4) begin
         a = 17'($urandom);
         d0 = 8'($urandom);
         d1 = 8'($urandom);
         m = 1'($urandom);
         wr2(a, d0, d1, m);
         rd2(a, d0, d1, ~m, -1);
      end
      wrsr(8'h80);
      wp_n = 1'b0;
      wrsr(8'h0C);
      wp_n = 1'b1;
      wrsr(8'h00);
      // Sleep: status read gets no answer until wake
      cmd(CMD_SLEEP, 1'b0);
      mst_u.start(1'b1);
      mst_u.xfer(CMD_RDSR, 8, -1, rx);
      mst_u.xfer(8'h00, 8, -1, rx);
      mst_u.stop;
      check(rx, 8'hFF);
      cmd(CMD_WAKE, 1'b0);
      cmd(CMD_WRDI, 1'b1);
      sr[SR_WEL] = 1'b0;
      rdsr(1'b0);
      check({7'h00, wr_ready}, 8'h01);
      print_verdict;
   end
   initial begin
      #500000;
      error_cnt++;
      print_verdict;
   end
endmodule
